/* rtl/gtf_pkg.sv */
package gtf_pkg;
	localparam int CHG_W = 16;
	localparam int VOLT_W = 16;
	localparam int TIME_W = 8;
	localparam int CNT_W = 16;
	localparam int ACC_W = 24;
	localparam int CLK_PERIOD_PS = 5000;
	// Dwell times are counted in whole seconds
	localparam int TICK_MS = 1000;
	localparam longint TICK_CYCLES_DFLT = longint'(TICK_MS) * 64'd1000000000 / longint'(CLK_PERIOD_PS);
	localparam int TICK_W = 28;
	localparam logic [15:0] PACK_CFG_RST = 16'ha137;
	localparam logic [15:0] PACK_CFG_MASK = 16'hff3f;
	localparam int PCFG_SHDN_PU = 3;
	localparam int PCFG_SHDN_POL = 2;
	localparam int PCFG_SHDN_EN = 1;
	localparam logic [7:0] CFG_B_RST = 8'h00;
	localparam logic [7:0] CFG_B_MASK = 8'h93;
	localparam int CFGB_FUSE = 7;
	localparam int CFGB_TRIP = 4;
	localparam int CFGB_SELFDSG = 1;
	localparam int CFGB_TDIFF = 0;
	localparam logic CFG_C_RST = 1'b1;
	localparam logic [6:0] INT_EN_RST = 7'h00;
	localparam int NUM_SRC = 7;
	localparam int SRC_TDIFF = 0;
	localparam int SRC_SELFDSG = 1;
	localparam int SRC_OV = 2;
	localparam int SRC_UV = 3;
	localparam int SRC_CHG_HOT = 4;
	localparam int SRC_DSG_HOT = 5;
	localparam int SRC_WARN = 6;
endpackage

/* rtl/gtf_flags.sv */
`timescale 1ns/1ps
// Function
// - Set warn flag when charge at/below set
// - Clear warn flag when charge at/above clear
// - Set final flag when charge reaches set
// - Clear final flag when charge at/above clear
// - Undervoltage flag after dwell below set threshold
// - Clear undervoltage flag above clear threshold
// - Overvoltage flag after dwell below set threshold
// - Clear overvoltage flag above clear threshold
// - Cycle count plus one per threshold crossing
// - Pack configuration word readable and writable
// - Enables for fuse, trip, self-discharge, temp-difference
// - Enable for temperature-zone charge profile
// - Per-source interrupt enables for seven events
module gtf_flags
	import gtf_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = int'(TICK_CYCLES_DFLT)
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [CHG_W-1:0] nominal_available_charge,
	input wire logic [VOLT_W-1:0] cell_voltage,
	input wire logic [CHG_W-1:0] warn_set_thr,
	input wire logic [CHG_W-1:0] warn_clr_thr,
	input wire logic [CHG_W-1:0] final_set_thr,
	input wire logic [CHG_W-1:0] final_clr_thr,
	input wire logic [VOLT_W-1:0] uv_set_thr,
	input wire logic [TIME_W-1:0] uv_set_time,
	input wire logic [VOLT_W-1:0] uv_clr_thr,
	input wire logic [VOLT_W-1:0] ov_set_thr,
	input wire logic [TIME_W-1:0] ov_set_time,
	input wire logic [VOLT_W-1:0] ov_clr_thr,
	input wire logic dsg_charge_valid,
	input wire logic [CHG_W-1:0] dsg_charge,
	input wire logic [ACC_W-1:0] cycle_count_thr,
	input wire logic pack_cfg_wr,
	input wire logic [15:0] pack_cfg_wdata,
	input wire logic cfg_b_wr,
	input wire logic [7:0] cfg_b_wdata,
	input wire logic cfg_c_wr,
	input wire logic cfg_c_wdata,
	input wire logic int_en_wr,
	input wire logic [NUM_SRC-1:0] int_en_wdata,
	input wire logic charge_overtemp_flag,
	input wire logic discharge_overtemp_flag,
	input wire logic tdiff_raw,
	input wire logic selfdsg_raw,
	input wire logic trip_raw,
	input wire logic fuse_raw,
	output logic charge_level_warn_flag,
	output logic charge_level_final_flag,
	output logic cell_undervoltage_flag,
	output logic cell_overvoltage_flag,
	output logic [CNT_W-1:0] cycle_count,
	output logic [15:0] pack_cfg,
	output logic [7:0] cfg_b,
	output logic temp_zone_charge_profile,
	output logic [NUM_SRC-1:0] int_en,
	output logic temp_difference_detect,
	output logic self_discharge_detect,
	output logic battery_trip_point,
	output logic fuse_fire,
	output logic int_pulse,
	output logic shutdown_enable_pin_o,
	output logic shutdown_enable_pin_oe
);
	logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
	logic tick;
	logic warn_reg, warn_next, final_reg, final_next;
	logic uv_reg, uv_next, ov_reg, ov_next;
	logic [TIME_W-1:0] uv_cnt_reg, uv_cnt_next, ov_cnt_reg, ov_cnt_next;
	logic uv_cond, ov_cond, uv_set_now, ov_set_now;
	logic [ACC_W-1:0] acc_reg, acc_next;
	logic [CNT_W-1:0] cyc_reg, cyc_next;
	logic [15:0] pcfg_reg, pcfg_next;
	logic [7:0] cfgb_reg, cfgb_next;
	logic cfgc_reg, cfgc_next;
	logic [NUM_SRC-1:0] ien_reg, ien_next;
	logic [NUM_SRC-1:0] src, src_prev_reg;
	logic tdiff_reg, selfdsg_reg, trip_reg, fuse_reg, intp_reg, intp_next;
	logic shdn_o_reg, shdn_oe_reg, shdn_o_next, shdn_oe_next, shdn_act;

	// One-second enable from a free divider
	assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
	always_comb begin
		tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
		end
	end

	// Overvoltage set compares below its threshold; direction still to be confirmed
	assign uv_cond = (cell_voltage < uv_set_thr);
	assign ov_cond = (cell_voltage < ov_set_thr);
	assign uv_set_now = uv_cond && (uv_cnt_reg >= uv_set_time);
	assign ov_set_now = ov_cond && (ov_cnt_reg >= ov_set_time);

	// Set wins when thresholds overlap so a flag never chatters
	always_comb begin
		warn_next = warn_reg;
		final_next = final_reg;
		uv_next = uv_reg;
		ov_next = ov_reg;
		if (nominal_available_charge <= warn_set_thr) begin
			warn_next = 1'b1;
		end else if (nominal_available_charge >= warn_clr_thr) begin
			warn_next = 1'b0;
		end
		if (nominal_available_charge <= final_set_thr) begin
			final_next = 1'b1;
		end else if (nominal_available_charge >= final_clr_thr) begin
			final_next = 1'b0;
		end
		if (uv_set_now) begin
			uv_next = 1'b1;
		end else if (cell_voltage > uv_clr_thr) begin
			uv_next = 1'b0;
		end
		if (ov_set_now) begin
			ov_next = 1'b1;
		end else if (cell_voltage > ov_clr_thr) begin
			ov_next = 1'b0;
		end
		// Dwell counters saturate and restart when the condition lapses
		uv_cnt_next = !uv_cond ? '0 : (tick && uv_cnt_reg != '1) ? uv_cnt_reg + 1'b1 : uv_cnt_reg;
		ov_cnt_next = !ov_cond ? '0 : (tick && ov_cnt_reg != '1) ? ov_cnt_reg + 1'b1 : ov_cnt_reg;
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			warn_reg <= 1'b0;
			final_reg <= 1'b0;
			uv_reg <= 1'b0;
			ov_reg <= 1'b0;
			uv_cnt_reg <= '0;
			ov_cnt_reg <= '0;
		end else begin
			warn_reg <= warn_next;
			final_reg <= final_next;
			uv_reg <= uv_next;
			ov_reg <= ov_next;
			uv_cnt_reg <= uv_cnt_next;
			ov_cnt_reg <= ov_cnt_next;
		end
	end

	// Remainder carries over so no charge is lost between cycles
	always_comb begin
		acc_next = acc_reg;
		cyc_next = cyc_reg;
		if (dsg_charge_valid) begin
			acc_next = acc_reg + ACC_W'(dsg_charge);
		end
		if (acc_next > cycle_count_thr) begin
			acc_next = acc_next - cycle_count_thr;
			cyc_next = cyc_reg + 1'b1;
		end
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			acc_reg <= '0;
			cyc_reg <= '0;
		end else begin
			acc_reg <= acc_next;
			cyc_reg <= cyc_next;
		end
	end

	// Configuration words; reserved bits read as zero
	always_comb begin
		pcfg_next = pack_cfg_wr ? (pack_cfg_wdata & PACK_CFG_MASK) : pcfg_reg;
		cfgb_next = cfg_b_wr ? (cfg_b_wdata & CFG_B_MASK) : cfgb_reg;
		cfgc_next = cfg_c_wr ? cfg_c_wdata : cfgc_reg;
		ien_next = int_en_wr ? int_en_wdata : ien_reg;
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pcfg_reg <= PACK_CFG_RST;
			cfgb_reg <= CFG_B_RST;
			cfgc_reg <= CFG_C_RST;
			ien_reg <= INT_EN_RST;
		end else begin
			pcfg_reg <= pcfg_next;
			cfgb_reg <= cfgb_next;
			cfgc_reg <= cfgc_next;
			ien_reg <= ien_next;
		end
	end

	assign src[SRC_TDIFF] = tdiff_reg;
	assign src[SRC_SELFDSG] = selfdsg_reg;
	assign src[SRC_OV] = ov_reg;
	assign src[SRC_UV] = uv_reg;
	assign src[SRC_CHG_HOT] = charge_overtemp_flag;
	assign src[SRC_DSG_HOT] = discharge_overtemp_flag;
	assign src[SRC_WARN] = warn_reg;
	assign shdn_act = (|(src & ien_reg)) || trip_reg || fuse_reg;

	// Event is a rising source edge; the pin follows enabled levels
	always_comb begin
		intp_next = |(src & ~src_prev_reg & ien_reg);
		shdn_o_next = 1'b0;
		shdn_oe_next = 1'b0;
		if (pcfg_reg[PCFG_SHDN_EN]) begin
			if (pcfg_reg[PCFG_SHDN_PU]) begin
				shdn_o_next = shdn_act ~^ pcfg_reg[PCFG_SHDN_POL];
				shdn_oe_next = 1'b1;
			end else begin
				// Open drain can only pull low
				shdn_oe_next = (shdn_act ~^ pcfg_reg[PCFG_SHDN_POL]) == 1'b0;
			end
		end
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			src_prev_reg <= '0;
			tdiff_reg <= 1'b0;
			selfdsg_reg <= 1'b0;
			trip_reg <= 1'b0;
			fuse_reg <= 1'b0;
			intp_reg <= 1'b0;
			shdn_o_reg <= 1'b0;
			shdn_oe_reg <= 1'b0;
		end else begin
			src_prev_reg <= src;
			tdiff_reg <= tdiff_raw & cfgb_reg[CFGB_TDIFF];
			selfdsg_reg <= selfdsg_raw & cfgb_reg[CFGB_SELFDSG];
			trip_reg <= trip_raw & cfgb_reg[CFGB_TRIP];
			fuse_reg <= fuse_raw & cfgb_reg[CFGB_FUSE];
			intp_reg <= intp_next;
			shdn_o_reg <= shdn_o_next;
			shdn_oe_reg <= shdn_oe_next;
		end
	end

	assign charge_level_warn_flag = warn_reg;
	assign charge_level_final_flag = final_reg;
	assign cell_undervoltage_flag = uv_reg;
	assign cell_overvoltage_flag = ov_reg;
	assign cycle_count = cyc_reg;
	assign pack_cfg = pcfg_reg;
	assign cfg_b = cfgb_reg;
	assign temp_zone_charge_profile = cfgc_reg;
	assign int_en = ien_reg;
	assign temp_difference_detect = tdiff_reg;
	assign self_discharge_detect = selfdsg_reg;
	assign battery_trip_point = trip_reg;
	assign fuse_fire = fuse_reg;
	assign int_pulse = intp_reg;
	assign shutdown_enable_pin_o = shdn_o_reg;
	assign shutdown_enable_pin_oe = shdn_oe_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence s_uv_dwelt;
		uv_cond && (uv_cnt_reg >= uv_set_time);
	endsequence
	sequence s_uv_rise;
		!uv_reg ##1 uv_reg;
	endsequence
	a_warn_set: assert property (nominal_available_charge <= warn_set_thr |=> warn_reg)
		else $error("warn flag not set");
	a_warn_clear: assert property ((nominal_available_charge >= warn_clr_thr)
		&& (nominal_available_charge > warn_set_thr) |=> !warn_reg)
		else $error("warn flag not cleared");
	a_final_set: assert property (nominal_available_charge <= final_set_thr |=> final_reg)
		else $error("final flag not set");
	a_final_clear: assert property ((nominal_available_charge >= final_clr_thr)
		&& (nominal_available_charge > final_set_thr) |=> !final_reg)
		else $error("final flag not cleared");
	a_uv_dwell_met: assert property (s_uv_rise |-> $past(uv_cond) && $past(uv_cnt_reg) >= $past(uv_set_time))
		else $error("undervoltage flag set early");
	a_uv_dwell_set: assert property (s_uv_dwelt |=> uv_reg)
		else $error("undervoltage flag missed");
	a_uv_clear: assert property (cell_voltage > uv_clr_thr && !uv_set_now |=> !uv_reg)
		else $error("undervoltage flag not cleared");
	a_ov_set: assert property (ov_set_now |=> ov_reg ##0 $past(ov_cond))
		else $error("overvoltage flag not set");
	a_ov_clear: assert property (cell_voltage > ov_clr_thr && !ov_set_now |=> !ov_reg)
		else $error("overvoltage flag not cleared");
	a_cycle_step: assert property (cyc_reg != $past(cyc_reg) |-> cyc_reg == $past(cyc_reg) + 1'b1)
		else $error("cycle count jumped");
	a_pcfg_write: assert property (pack_cfg_wr |=> pcfg_reg == ($past(pack_cfg_wdata) & PACK_CFG_MASK))
		else $error("pack config write lost");
	a_tdiff_gate: assert property (!cfgb_reg[CFGB_TDIFF] |=> !tdiff_reg)
		else $error("disabled function active");
	a_profile_en: assert property (cfg_c_wr |=> cfgc_reg == $past(cfg_c_wdata))
		else $error("profile enable write lost");
	a_dwell_restart: assert property (!uv_cond |=> uv_cnt_reg == '0)
		else $error("dwell timer did not restart");
	a_int_gate: assert property (int_pulse |-> $past(|(src & ~src_prev_reg & ien_reg)))
		else $error("interrupt without enabled event");
endmodule

/* tb/gtf_host.sv */
`timescale 1ns/1ps
// Host side: watches the shutdown line and counts interrupt pulses
module gtf_host (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic int_pulse,
	input wire logic shdn_o,
	input wire logic shdn_oe,
	output logic shdn_line,
	output logic [15:0] int_count
);
	// Board pull-up, so a released line reads high
	assign shdn_line = shdn_oe ? shdn_o : 1'b1;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			int_count <= 16'h0000;
		else if (int_pulse === 1'b1)
			int_count <= int_count + 16'h0001;
	end
endmodule

/* tb/gtf_flags_tb.sv */
`timescale 1ns/1ps
module gtf_flags_tb;
	import gtf_pkg::*;
	logic mclk = 0, rstn = 0, dsg_charge_valid = 0, pack_cfg_wr = 0, cfg_b_wr = 0, cfg_c_wr = 0, cfg_c_wdata = 0;
	logic int_en_wr = 0, charge_overtemp_flag = 0, discharge_overtemp_flag = 0;
	logic tdiff_raw = 0, selfdsg_raw = 0, trip_raw = 0, fuse_raw = 0;
	logic [15:0] nominal_available_charge = 16'hffff, cell_voltage = 16'h0e10, dsg_charge = 16'h0190;
	logic [15:0] warn_set_thr = 16'h0064, warn_clr_thr = 16'h00c8, final_set_thr = 16'h0032, final_clr_thr = 16'h0078;
	logic [15:0] uv_set_thr = 16'h0c80, uv_clr_thr = 16'h0d48, ov_set_thr = 16'h0c00, ov_clr_thr = 16'h0c40;
	logic [7:0] uv_set_time = 8'h03, ov_set_time = 8'h00, cfg_b_wdata = 8'h00, cfg_b;
	logic [23:0] cycle_count_thr = 24'h0003e8;
	logic [15:0] pack_cfg_wdata = 16'h0000, pack_cfg, cycle_count, int_count, d;
	logic [6:0] int_en_wdata = 7'h00, int_en;
	logic charge_level_warn_flag, charge_level_final_flag, cell_undervoltage_flag, cell_overvoltage_flag;
	logic temp_zone_charge_profile, temp_difference_detect, self_discharge_detect, battery_trip_point, fuse_fire;
	logic int_pulse, shutdown_enable_pin_o, shutdown_enable_pin_oe, shdn_line;
	logic [19:0] exp_q[$];
	logic [19:0] e;
	logic [15:0] chg[7] = '{16'h0096, 16'h0064, 16'h0032, 16'h005a, 16'h0078, 16'h00c7, 16'h00c8};
	logic [6:0] ew = 7'b0111110, ef = 7'b0001100;
	int num_errors = 0, cmp_count = 0, np[3] = '{3, 2, 1}, nc[3] = '{1, 1, 2};
	integer seed = 32'h140a1a0d;
	event got;

	gtf_flags #(.TICK_CYCLES(10)) u_dut (.mclk, .rstn, .nominal_available_charge, .cell_voltage, .warn_set_thr,
		.warn_clr_thr, .final_set_thr, .final_clr_thr, .uv_set_thr, .uv_set_time, .uv_clr_thr, .ov_set_thr,
		.ov_set_time, .ov_clr_thr, .dsg_charge_valid, .dsg_charge, .cycle_count_thr, .pack_cfg_wr, .pack_cfg_wdata,
		.cfg_b_wr, .cfg_b_wdata, .cfg_c_wr, .cfg_c_wdata, .int_en_wr, .int_en_wdata, .charge_overtemp_flag,
		.discharge_overtemp_flag, .tdiff_raw, .selfdsg_raw, .trip_raw, .fuse_raw, .charge_level_warn_flag,
		.charge_level_final_flag, .cell_undervoltage_flag, .cell_overvoltage_flag, .cycle_count, .pack_cfg, .cfg_b,
		.temp_zone_charge_profile, .int_en, .temp_difference_detect, .self_discharge_detect, .battery_trip_point,
		.fuse_fire, .int_pulse, .shutdown_enable_pin_o, .shutdown_enable_pin_oe);
	gtf_host u_host (.mclk, .rstn, .int_pulse, .shdn_o(shutdown_enable_pin_o), .shdn_oe(shutdown_enable_pin_oe),
		.shdn_line, .int_count);

	always #2.5 mclk = ~mclk;

	task step(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Note an expectation; the watcher drains the queue in this same step
	task ex(input logic [3:0] s, input logic [15:0] v);
		exp_q.push_back({s, v});
		->got;
	endtask
	task cmp_word(input logic [15:0] g, input logic [15:0] x);
		cmp_count++;
		if (g !== x) begin
			num_errors++;
			$display("mismatch at %0t: sel %0d got %h exp %h", $time, e[19:16], g, x);
		end
	endtask
	task cmp_bit(input logic g, input logic x);
		cmp_word({15'h0000, g}, {15'h0000, x});
	endtask
	task complete_run;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Outputs are registered, so a falling-edge look sees settled values
	always @(got) begin
		while (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			case (e[19:16])
				4'h0: cmp_bit(charge_level_warn_flag, e[0]);
				4'h1: cmp_bit(charge_level_final_flag, e[0]);
				4'h2: cmp_bit(cell_undervoltage_flag, e[0]);
				4'h3: cmp_bit(cell_overvoltage_flag, e[0]);
				4'h4: cmp_word(cycle_count, e[15:0]);
				4'h5: cmp_word(pack_cfg, e[15:0]);
				4'h6: cmp_word({8'h00, cfg_b}, e[15:0]);
				4'h7: cmp_bit(temp_zone_charge_profile, e[0]);
				4'h8: cmp_word({9'h000, int_en}, e[15:0]);
				4'h9: cmp_word({12'h000, temp_difference_detect, self_discharge_detect, battery_trip_point, fuse_fire}, e[15:0]);
				4'ha: cmp_word(int_count, e[15:0]);
				default: cmp_bit(shdn_line, e[0]);
			endcase
		end
	end

	initial begin
		#20000;
		num_errors++;
		complete_run();
	end

	initial begin
		step(5);
		rstn = 1;
		step(2);
		ex(5, 16'ha137);
		ex(6, 16'h0000);
		ex(7, 16'h0001);
		ex(8, 16'h0000);
		ex(4, 16'h0000);
		ex(11, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			nominal_available_charge = chg[i];
			step(2);
			ex(0, {15'h0000, ew[i]});
			ex(1, {15'h0000, ef[i]});
		end
		ex(10, 16'h0000);
		// Two short dips must not add up to one long dwell
		cell_voltage = 16'h0c1c;
		step(19);
		cell_voltage = 16'h0cb2;
		step(1);
		cell_voltage = 16'h0c1c;
		step(19);
		ex(2, 16'h0000);
		step(30);
		ex(2, 16'h0001);
		cell_voltage = 16'h0d48;
		step(2);
		ex(2, 16'h0001);
		cell_voltage = 16'h0e10;
		step(2);
		ex(2, 16'h0000);
		cell_voltage = 16'h0bb8;
		step(2);
		ex(3, 16'h0001);
		cell_voltage = 16'h0c1c;
		step(2);
		ex(3, 16'h0001);
		cell_voltage = 16'h0e10;
		step(2);
		ex(3, 16'h0000);
		for (int k = 0; k < 3; k++) begin
			repeat (np[k]) begin
				dsg_charge_valid = 1;
				step(1);
				dsg_charge_valid = 0;
				step(1);
			end
			ex(4, nc[k][15:0]);
		end
		{tdiff_raw, selfdsg_raw, trip_raw, fuse_raw} = 4'hf;
		step(2);
		ex(9, 16'h0000);
		cfg_b_wdata = 8'hff;
		cfg_b_wr = 1;
		step(1);
		cfg_b_wr = 0;
		step(1);
		ex(6, 16'h0093);
		ex(9, 16'h000f);
		// The pin register sits one cycle behind the gated functions
		step(1);
		ex(11, 16'h0001);
		int_en_wdata = 7'h10;
		int_en_wr = 1;
		step(1);
		int_en_wr = 0;
		charge_overtemp_flag = 1;
		discharge_overtemp_flag = 1;
		step(3);
		ex(8, 16'h0010);
		ex(10, 16'h0001);
		d = 16'($random(seed));
		pack_cfg_wdata = d;
		pack_cfg_wr = 1;
		int_en_wdata = 7'($random(seed));
		int_en_wr = 1;
		cfg_c_wr = 1;
		step(1);
		{pack_cfg_wr, int_en_wr, cfg_c_wr} = 3'h0;
		step(1);
		ex(5, d & 16'hff3f);
		ex(8, {9'h000, int_en_wdata});
		ex(7, 16'h0000);
		// Let the watcher drain the last notes before the verdict
		step(1);
		complete_run();
	end
endmodule
